// ===== common/tpc_defs.svh
// register indices, field codes, reset values and prescaler counts
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH
`define TPC_IX_CTRL 6'h00
`define TPC_IX_PRST 6'h03
`define TPC_IX_CNT 6'h04
`define TPC_IX_CMP 6'h07
`define TPC_IX_TOP 6'h0B
`define TPC_IX_STAT 6'h0C
`define TPC_IX_MASK 6'h0D
`define TPC_CS_DIV1 3'h1
`define TPC_CS_DIV8 3'h2
`define TPC_CS_DIV64 3'h3
`define TPC_CS_DIV256 3'h4
`define TPC_CS_DIV1024 3'h5
`define TPC_RES8 16'h00FF
`define TPC_RES9 16'h01FF
`define TPC_RES10 16'h03FF
`define TPC_FULL 16'hFFFF
`define TPC_RST_CTRL 12'h000
`define TPC_RST_VAL 16'h0000
`define TPC_RST_STAT 7'h00
`define TPC_RST_PRESC 10'h000
`define TPC_RESP_OKAY 2'h0
`define TPC_RESP_SLVERR 2'h2
`endif

// ===== common/tpc_pkg.sv
// types shared by the timer and pwm compare unit
`default_nettype none
package tpc_pkg;
  typedef enum logic [2:0] {
    TPC_NORMAL = 3'h0,
    TPC_CTC = 3'h1,
    TPC_FAST = 3'h2,
    TPC_PHASE = 3'h3,
    TPC_PFC = 3'h4
  } tpc_mode_t;
  typedef struct packed {
    logic [1:0] res;
    logic [1:0] com_b;
    logic [1:0] com_a;
    logic [2:0] csel;
    tpc_mode_t mode;
  } tpc_ctrl_t;
endpackage : tpc_pkg
`default_nettype wire

// ===== rtl/tpc_top.sv
// timer/counter unit: one wide and two narrow counters, compare, pwm, axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defs.svh"
module tpc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [3:0] compare_output_pin,
  output logic irq
);
  localparam logic [1:0] CH_TMR [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
  localparam logic [1:0] TMR_CHA [3] = '{2'h0, 2'h1, 2'h3};

  tpc_pkg::tpc_ctrl_t ctrl_q [3];
  tpc_pkg::tpc_ctrl_t ctrl_d [3];
  logic [15:0] cnt_q [3];
  logic [15:0] cnt_d [3];
  logic [2:0] dir_q, dir_d;
  logic [15:0] cmp_q [4];
  logic [15:0] cmp_d [4];
  logic [15:0] buf_q [4];
  logic [15:0] buf_d [4];
  logic [15:0] top_q, top_d;
  logic [3:0] oc_q, oc_d;
  logic [1:0] coma_q [4];
  logic [1:0] coma_d [4];
  logic [9:0] presc_q, presc_d;
  logic [6:0] stat_q, stat_d, mask_q, mask_d, set, clr;
  logic irq_q, irq_d;
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d, wd_q, wd_d, wv, wm;
  logic [3:0] ws_q, ws_d;
  logic [7:0] awa_q, awa_d;
  logic awh_q, awh_d, wh_q, wh_d;
  logic [2:0] tick, pwm, ph, upd, wrap, cwr;
  logic [15:0] rmask [3];
  logic [15:0] lim [3];
  logic [15:0] top [3];
  logic [15:0] cv [3];
  logic [3:0] match;
  logic prst_w;
  logic [5:0] ix, ixo;
  logic [32:0] wcur, rcur;
  logic [1:0] com;
  logic [1:0] t;

  // {error, data} for one register index; unmapped indices flag an error
  function automatic logic [32:0] rd_fn(input logic [5:0] ri);
    logic [32:0] r;
    r = '0;
    if (ri < `TPC_IX_PRST) begin
      r[11:0] = ctrl_q[ri[1:0]];
    end else if (ri == `TPC_IX_PRST) begin
      r = '0;
    end else if (ri < `TPC_IX_CMP) begin
      r[15:0] = cnt_q[2'(ri - `TPC_IX_CNT)];
    end else if (ri == `TPC_IX_CMP || ri == 6'h0A) begin
      r[15:0] = buf_q[2'(ri - `TPC_IX_CMP)];
    end else if (ri < `TPC_IX_TOP) begin
      r[15:0] = cmp_q[2'(ri - `TPC_IX_CMP)];
    end else if (ri == `TPC_IX_TOP) begin
      r[15:0] = top_q;
    end else if (ri == `TPC_IX_STAT) begin
      r[6:0] = stat_q;
    end else if (ri == `TPC_IX_MASK) begin
      r[6:0] = mask_q;
    end else begin
      r[32] = 1'b1;
    end
    return r;
  endfunction : rd_fn

  always_comb begin
    ctrl_d = ctrl_q;
    cnt_d = cnt_q;
    dir_d = dir_q;
    cmp_d = cmp_q;
    buf_d = buf_q;
    top_d = top_q;
    oc_d = oc_q;
    coma_d = coma_q;
    mask_d = mask_q;
    // prescaler advances on every aclk cycle with ce high unless a PRST write restarts it, no other divider in its path
    presc_d = presc_q + 10'h001;
    set = '0;
    clr = '0;
    tick = '0;
    pwm = '0;
    ph = '0;
    upd = '0;
    wrap = '0;
    cwr = '0;
    match = '0;
    prst_w = 1'b0;
    com = 2'h0;
    t = 2'h0;
    for (int i = 0; i < 3; i++) begin
      case (ctrl_q[i].csel)
        `TPC_CS_DIV1: tick[i] = 1'b1;
        `TPC_CS_DIV8: tick[i] = &presc_q[2:0];
        `TPC_CS_DIV64: tick[i] = &presc_q[5:0];
        `TPC_CS_DIV256: tick[i] = &presc_q[7:0];
        `TPC_CS_DIV1024: tick[i] = &presc_q[9:0];
        default: tick[i] = 1'b0;
      endcase
      pwm[i] = ctrl_q[i].mode inside {tpc_pkg::TPC_FAST, tpc_pkg::TPC_PHASE, tpc_pkg::TPC_PFC};
      ph[i] = ctrl_q[i].mode inside {tpc_pkg::TPC_PHASE, tpc_pkg::TPC_PFC};
      if (i != 1) begin
        rmask[i] = `TPC_RES8;
      end else if (ctrl_q[i].mode == tpc_pkg::TPC_PFC) begin
        rmask[i] = `TPC_FULL;
      end else begin
        case (ctrl_q[i].res)
          2'h0: rmask[i] = `TPC_RES8;
          2'h1: rmask[i] = `TPC_RES9;
          2'h2: rmask[i] = `TPC_RES10;
          default: rmask[i] = `TPC_FULL;
        endcase
      end
      lim[i] = pwm[i] ? rmask[i] : ((i == 1) ? `TPC_FULL : `TPC_RES8);
      cv[i] = cnt_q[i] & lim[i];
      if (ctrl_q[i].mode == tpc_pkg::TPC_CTC) begin
        top[i] = cmp_q[TMR_CHA[i]] & lim[i];
      end else if (i == 1 && pwm[i] && rmask[i] == `TPC_FULL) begin
        top[i] = top_q;
      end else begin
        top[i] = lim[i];
      end
      if (tick[i]) begin
        if (ph[i] && !dir_q[i]) begin
          if (cv[i] == top[i]) begin
            dir_d[i] = 1'b1;
            cnt_d[i] = cv[i] - 16'h0001;
            upd[i] = ctrl_q[i].mode == tpc_pkg::TPC_PHASE;
          end else begin
            cnt_d[i] = cv[i] + 16'h0001;
          end
        end else if (ph[i]) begin
          if (cv[i] == 16'h0000) begin
            dir_d[i] = 1'b0;
            cnt_d[i] = 16'h0001;
            wrap[i] = 1'b1;
            upd[i] = ctrl_q[i].mode == tpc_pkg::TPC_PFC;
          end else begin
            cnt_d[i] = cv[i] - 16'h0001;
          end
        end else if (cv[i] == top[i]) begin
          // clearing on this tick means the count sat at top for its whole last period
          cnt_d[i] = 16'h0000;
          wrap[i] = 1'b1;
          upd[i] = ctrl_q[i].mode == tpc_pkg::TPC_FAST;
        end else begin
          cnt_d[i] = cv[i] + 16'h0001;
        end
      end
      set[4 + i] = wrap[i];
    end
    for (int c = 0; c < 4; c++) begin
      t = CH_TMR[c];
      com = (c == 2) ? ctrl_q[1].com_b : ctrl_q[t].com_a;
      if (upd[t]) begin
        cmp_d[c] = buf_q[c] & rmask[t];
      end
      match[c] = tick[t] && cv[t] == (cmp_q[c] & lim[t]);
      if (match[c]) begin
        // a new select only reaches the pin here, at a match
        coma_d[c] = com;
        set[c] = 1'b1;
        case (com)
          2'h1: oc_d[c] = ~oc_q[c];
          2'h2: oc_d[c] = ph[t] && dir_q[t];
          2'h3: oc_d[c] = !(ph[t] && dir_q[t]);
          default: oc_d[c] = oc_q[c];
        endcase
      end else if (wrap[t] && ctrl_q[t].mode == tpc_pkg::TPC_FAST) begin
        case (coma_q[c])
          2'h2: oc_d[c] = 1'b1;
          2'h3: oc_d[c] = 1'b0;
          default: oc_d[c] = oc_q[c];
        endcase
      end
    end
    awready_d = awready_q;
    wready_d = wready_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    awh_d = awh_q;
    wh_d = wh_q;
    ix = awa_q[7:2];
    ixo = 6'h00;
    wcur = rd_fn(ix);
    rcur = rd_fn(s_axi_araddr[7:2]);
    wm = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
    wv = (wcur[31:0] & ~wm) | (wd_q & wm);
    if (s_axi_awvalid && awready_q) begin
      awh_d = 1'b1;
      awa_d = s_axi_awaddr;
      awready_d = 1'b0;
    end
    if (s_axi_wvalid && wready_q) begin
      wh_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
      wready_d = 1'b0;
    end
    if (awh_q && wh_q && !bvalid_q) begin
      awh_d = 1'b0;
      wh_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wcur[32] ? `TPC_RESP_SLVERR : `TPC_RESP_OKAY;
      if (ix < `TPC_IX_PRST) begin
        ctrl_d[ix[1:0]] = tpc_pkg::tpc_ctrl_t'(wv[11:0]);
      end else if (ix == `TPC_IX_PRST) begin
        if (wv[0]) begin
          presc_d = `TPC_RST_PRESC;
          prst_w = 1'b1;
        end
      end else if (ix < `TPC_IX_CMP) begin
        ixo = ix - `TPC_IX_CNT;
        cnt_d[ixo[1:0]] = wv[15:0] & ((ixo == 6'h01) ? `TPC_FULL : `TPC_RES8);
        cwr[ixo[1:0]] = 1'b1;
      end else if (ix < `TPC_IX_TOP) begin
        ixo = ix - `TPC_IX_CMP;
        t = CH_TMR[ixo[1:0]];
        buf_d[ixo[1:0]] = wv[15:0] & ((t == 2'h1) ? `TPC_FULL : `TPC_RES8);
        // outside pwm the write lands in the active compare at once
        if (!pwm[t]) begin
          cmp_d[ixo[1:0]] = buf_d[ixo[1:0]];
        end
      end else if (ix == `TPC_IX_TOP) begin
        top_d = wv[15:0];
      end else if (ix == `TPC_IX_STAT) begin
        clr = wv[6:0];
      end else if (ix == `TPC_IX_MASK) begin
        mask_d = wv[6:0];
      end
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
      awready_d = 1'b1;
      wready_d = 1'b1;
    end
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rdata_d = rcur[31:0];
      rresp_d = rcur[32] ? `TPC_RESP_SLVERR : `TPC_RESP_OKAY;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
    // an event in the clearing cycle survives
    stat_d = (stat_q & ~clr) | set;
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 3; i++) begin
        ctrl_q[i] <= tpc_pkg::tpc_ctrl_t'(`TPC_RST_CTRL);
        cnt_q[i] <= `TPC_RST_VAL;
      end
      for (int c = 0; c < 4; c++) begin
        cmp_q[c] <= `TPC_RST_VAL;
        buf_q[c] <= `TPC_RST_VAL;
        coma_q[c] <= 2'h0;
      end
      dir_q <= 3'h0;
      top_q <= `TPC_RST_VAL;
      oc_q <= 4'h0;
      presc_q <= `TPC_RST_PRESC;
      stat_q <= `TPC_RST_STAT;
      mask_q <= `TPC_RST_STAT;
      irq_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      arready_q <= 1'b1;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      bresp_q <= `TPC_RESP_OKAY;
      rresp_q <= `TPC_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      awa_q <= 8'h00;
      awh_q <= 1'b0;
      wh_q <= 1'b0;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      cnt_q <= cnt_d;
      cmp_q <= cmp_d;
      buf_q <= buf_d;
      coma_q <= coma_d;
      dir_q <= dir_d;
      top_q <= top_d;
      oc_q <= oc_d;
      presc_q <= presc_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      awa_q <= awa_d;
      awh_q <= awh_d;
      wh_q <= wh_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign compare_output_pin = oc_q;
  assign irq = irq_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_WIDE_CNT_RES: assert property (ce && tick[1] && ctrl_q[1].mode == tpc_pkg::TPC_FAST
    && ctrl_q[1].res == 2'h0 && !cwr[1] |=> cnt_q[1][15:8] == 8'h00)
    else $error("wide counter above 8-bit pwm resolution");
  AST_CMP_RES: assert property (ce && upd[1] && ctrl_q[1].res == 2'h1
    && ctrl_q[1].mode != tpc_pkg::TPC_PFC |=> cmp_q[1][15:9] == 7'h00)
    else $error("compare high bits not cleared at top");
  AST_CTC_CLEAR: assert property (ce && tick[0] && ctrl_q[0].mode == tpc_pkg::TPC_CTC
    && cnt_q[0] == cmp_q[0] && !cwr[0] |=> cnt_q[0] == 16'h0000)
    else $error("ctc did not clear after the matching period");
  AST_FLAG: assert property (ce && tick[2] && cnt_q[2][7:0] == cmp_q[3][7:0] |=> stat_q[3])
    else $error("compare flag missing after match");
  AST_BUF_HOLD: assert property (ce && pwm[1] && !upd[1] |=> $stable(cmp_q[1]))
    else $error("active compare changed away from top");
  AST_RD_ACTIVE: assert property (ce && s_axi_arvalid && arready_q
    && s_axi_araddr[7:2] == 6'h08 |=> rdata_q[15:0] == $past(cmp_q[1]))
    else $error("wide compare read not the active value");
  AST_RD_BUF: assert property (ce && s_axi_arvalid && arready_q
    && s_axi_araddr[7:2] == `TPC_IX_CMP |=> rdata_q[15:0] == $past(buf_q[0]))
    else $error("narrow compare read not the buffer");
  AST_PIN_NARROW: assert property (ce && !match[0] && ctrl_q[0].mode != tpc_pkg::TPC_FAST
    |=> $stable(compare_output_pin[0]))
    else $error("narrow pin moved without a match");
  AST_PIN_WIDE: assert property (ce && !match[2] && ctrl_q[1].mode != tpc_pkg::TPC_FAST
    |=> $stable(compare_output_pin[2]))
    else $error("wide pin moved without a match");
  AST_RST_PIN: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> compare_output_pin == 4'h0 && !irq)
    else $error("pins not low after reset");
  AST_PRESC_RST: assert property (ce && prst_w |=> presc_q == 10'h000)
    else $error("prescaler not restarted");
  AST_STEP: assert property (ce && tick[2] && ctrl_q[2].mode == tpc_pkg::TPC_NORMAL
    && !cwr[2] && cnt_q[2] < 16'h00FF |=> cnt_q[2] == 16'($past(cnt_q[2]) + 16'h0001))
    else $error("counter did not advance by one");
  COV_PFC: cover property (ctrl_q[1].mode == tpc_pkg::TPC_PFC && upd[1]);
  COV_CTC: cover property (ctrl_q[0].mode == tpc_pkg::TPC_CTC && wrap[0] ##1 cnt_q[0] == 16'h0000);
  COV_IRQ: cover property (!irq ##1 irq);
endmodule : tpc_top
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the timer and pwm compare unit
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defs.svh"
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, v;
  logic [3:0] compare_output_pin;
  logic [63:0] gaps;
  logic [65:0] e;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  logic [1:0] r;
  logic lvl;
  tpc_pkg::tpc_mode_t pm;
  int fails = 0;
  int n_checks = 0;
  int seed = 34;

  tpc_top tpc_top_inst (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .compare_output_pin, .irq);
  tpc_load_model tpc_load_model_inst (.aclk(aclk), .pin_level(compare_output_pin),
    .rise_gap(gaps));

  always #4 aclk = ~aclk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tmo(input int n);
    if (n >= 1000) begin
      fails++;
      $display("wrong value at %0t: handshake timed out", $time);
      print_verdict();
    end
  endtask : tmo

  task automatic idle(input int c);
    repeat (c) @(posedge aclk);
  endtask : idle

  task automatic wr(input logic [5:0] ix, input logic [31:0] d,
                    input logic [1:0] resp = `TPC_RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    bq.push_back(resp);
    s_axi_awaddr <= {ix, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 1000);
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask : wr

  task automatic rd(input logic [5:0] ix, input logic [31:0] exp,
                    input logic [31:0] m = 32'hFFFF_FFFF, input logic [1:0] resp = `TPC_RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    rq.push_back({resp, m, exp & m});
    s_axi_araddr <= {ix, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 1000);
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask : rd

  function automatic logic [31:0] cw(input logic [1:0] res, input logic [1:0] ca,
                                     input logic [1:0] cb, input logic [2:0] cs,
                                     input tpc_pkg::tpc_mode_t m);
    tpc_pkg::tpc_ctrl_t c;
    c = '{res: res, com_b: cb, com_a: ca, csel: cs, mode: m};
    return {20'h0_0000, c};
  endfunction : cw

  // results come back in request order, so the oldest note always matches
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      check(s_axi_rdata & e[63:32], e[31:0]);
      check(32'(s_axi_rresp), 32'(e[65:64]));
    end
    if (s_axi_bvalid && s_axi_bready) check(32'(s_axi_bresp), 32'(bq.pop_front()));
  end

  initial begin
    repeat (5) @(posedge aclk);
    check(32'(compare_output_pin), 32'h0000_0000);
    check(32'(irq), 32'h0000_0000);
    aresetn <= 1'b1;
    rd(`TPC_IX_CTRL, 32'h0000_0000);
    rd(6'h0E, 32'h0000_0000, 32'hFFFF_FFFF, `TPC_RESP_SLVERR);
    wr(6'h0E, 32'h0000_0001, `TPC_RESP_SLVERR);
    // the divider is restarted here, before timer 0 is started on it
    wr(`TPC_IX_PRST, 32'h0000_0001);
    rd(`TPC_IX_PRST, 32'h0000_0000);
    wr(`TPC_IX_CMP, 32'h0000_0002);
    wr(`TPC_IX_CTRL, cw(2'h0, 2'h1, 2'h0, `TPC_CS_DIV8, tpc_pkg::TPC_CTC));
    idle(150);
    check(32'(gaps[15:0]), 32'h0000_0030);
    check(32'(irq), 32'h0000_0000);
    rd(`TPC_IX_STAT, 32'h0000_0001, 32'h0000_0001);
    wr(`TPC_IX_MASK, 32'h0000_0001);
    idle(2);
    check(32'(irq), 32'h0000_0001);
    // the timer keeps matching while the pin is disconnected, so a lost level would show
    wr(`TPC_IX_CTRL, cw(2'h0, 2'h0, 2'h0, `TPC_CS_DIV8, tpc_pkg::TPC_CTC));
    lvl = compare_output_pin[0];
    idle(50);
    check(32'(compare_output_pin[0]), 32'(lvl));
    wr(`TPC_IX_CTRL, cw(2'h0, 2'h3, 2'h0, 3'h0, tpc_pkg::TPC_CTC));
    idle(20);
    check(32'(compare_output_pin[0]), 32'(lvl));
    wr(`TPC_IX_CTRL, cw(2'h0, 2'h2, 2'h0, `TPC_CS_DIV8, tpc_pkg::TPC_CTC));
    idle(30);
    check(32'(compare_output_pin[0]), 32'h0000_0000);
    wr(`TPC_IX_CTRL, cw(2'h0, 2'h3, 2'h0, `TPC_CS_DIV8, tpc_pkg::TPC_CTC));
    idle(30);
    check(32'(compare_output_pin[0]), 32'h0000_0001);
    wr(`TPC_IX_CTRL, cw(2'h0, 2'h0, 2'h0, 3'h0, tpc_pkg::TPC_CTC));
    wr(`TPC_IX_STAT, 32'h0000_007F);
    idle(2);
    check(32'(irq), 32'h0000_0000);
    rd(`TPC_IX_STAT, 32'h0000_0000, 32'h0000_0001);
    for (r = 2'h0; r < 2'h3; r++) begin
      wr(6'h01, cw(r, 2'h2, 2'h0, `TPC_CS_DIV1, tpc_pkg::TPC_FAST));
      wr(6'h05, 32'h0000_FFF0);
      wr(6'h08, 32'h0000_0040);
      wr(6'h09, 32'h0000_FFFF);
      idle(3200);
      rd(6'h05, 32'h0000_0000, (32'h0000_FF00 << r) & 32'h0000_FFFF);
      rd(6'h09, (32'h0000_0100 << r) - 32'h0000_0001, 32'h0000_FFFF);
      check(32'(gaps[31:16]), 32'h0000_0100 << r);
    end
    wr(6'h01, cw(2'h0, 2'h2, 2'h0, 3'h0, tpc_pkg::TPC_FAST));
    lvl = compare_output_pin[1];
    wr(6'h08, 32'h0000_0077);
    rd(6'h08, 32'h0000_0040, 32'h0000_FFFF);
    wr(6'h01, cw(2'h0, 2'h3, 2'h0, 3'h0, tpc_pkg::TPC_FAST));
    idle(20);
    check(32'(compare_output_pin[1]), 32'(lvl));
    wr(6'h01, cw(2'h0, 2'h0, 2'h0, 3'h0, tpc_pkg::TPC_NORMAL));
    rd(6'h08, 32'h0000_0040, 32'h0000_FFFF);
    wr(6'h02, cw(2'h0, 2'h0, 2'h0, 3'h0, tpc_pkg::TPC_FAST));
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(6'h0A, v);
      wr(6'h09, v);
      rd(6'h0A, v, 32'h0000_00FF);
      rd(6'h09, v, 32'h0000_FFFF);
    end
    // timer 2 free-running: one toggle per 256-cycle period, so rises 512 apart
    wr(6'h02, cw(2'h0, 2'h1, 2'h0, 3'h0, tpc_pkg::TPC_NORMAL));
    wr(6'h0A, 32'h0000_0080);
    wr(6'h02, cw(2'h0, 2'h1, 2'h0, `TPC_CS_DIV1, tpc_pkg::TPC_NORMAL));
    idle(1100);
    check(32'(gaps[63:48]), 32'h0000_0200);
    rd(`TPC_IX_STAT, 32'h0000_0048, 32'h0000_0048);
    wr(`TPC_IX_TOP, 32'h0000_0010);
    for (int k = 0; k < 2; k++) begin
      pm = k ? tpc_pkg::TPC_PFC : tpc_pkg::TPC_PHASE;
      wr(6'h01, cw(2'h3, 2'h2, 2'h0, 3'h0, pm));
      wr(6'h05, 32'h0000_0000);
      wr(6'h08, 32'h0000_0004);
      wr(6'h01, cw(2'h3, 2'h2, 2'h0, `TPC_CS_DIV1, pm));
      idle(200);
      check(32'(gaps[31:16]), 32'h0000_0020);
    end
    idle(5);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire

// ===== verification/tpc_load_model.sv
// external load on the compare pins: measures spacing of rising edges
`timescale 1ns/1ps
`default_nettype none
module tpc_load_model (
  input wire logic aclk,
  input wire logic [3:0] pin_level,
  output logic [63:0] rise_gap
);
  // a passive load only listens, so timing is judged from edge spacing, not from levels
  logic [15:0] since_q [4] = '{default: 16'h0000};
  logic [3:0] prev_q = 4'h0;
  always @(posedge aclk) begin
    prev_q <= pin_level;
    for (int i = 0; i < 4; i++) begin
      since_q[i] <= since_q[i] + 16'h0001;
      if (pin_level[i] && !prev_q[i]) begin
        rise_gap[i*16 +: 16] <= since_q[i] + 16'h0001;
        since_q[i] <= 16'h0000;
      end
    end
  end
endmodule : tpc_load_model
`default_nettype wire
